// [logic/mtg_tx_top.sv]
// Transmit gap, frame builder and PHY control with Avalon-MM registers
// What this block does
// - Full duplex: back-to-back gap is programmed value plus three nibbles.
// - Half duplex: back-to-back gap is programmed value plus six nibbles.
// - Force-link bit 14 reports link up without a partner.
// - Bit 13 of second PHY control disables the twisted-pair transmitter.
// - Bit 10 of second PHY control disables jabber correction.
// - Loopback-disable honoured only when first-control bits 8 and 14 clear.
// - LED control register chooses what each LED output shows.
// - MAC generates preamble and start delimiter itself.
// - MAC pads short frames and appends CRC when configured.
// - One control byte precedes each frame and is read first.
// - Override bit makes per-frame CRC, pad and huge bits win.
// - Per-frame pad bit zero-pads short frames to 60 bytes.
// - Per-frame CRC clear appends none and checks last four bytes.
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mtg_tx_top
   import mtg_pkg::*;
#(
   parameter int JAB_LIMIT = 40000
) (
   // Clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Frame bytes from buffer memory
   input  wire logic [7:0]  fr_data,
   input  wire logic        fr_valid,
   input  wire logic        fr_last,
   output logic             fr_ready,
   // Pins
   input  wire logic        link_detect,
   input  wire logic        duplex_strap,
   output logic      [3:0]  tp_tx_data,
   output logic             tp_tx_en,
   output logic      [3:0]  loop_data,
   output logic             loop_valid,
   output logic             link_up,
   output logic             led_out_first,
   output logic             led_out_second
);
   import mtg_pkg::*;

   logic [7:0]  mac_control_three_q;
   logic [7:0]  back_to_back_gap_q;
   logic [15:0] phy_control_one_q;
   logic [15:0] phy_control_two_q;
   logic [15:0] led_control_q;
   logic [15:0] max_frame_length_q;
   logic        ack_q, pend_q, abort_q, under_q, crcb_q;
   logic        acc_wr;
   logic [2:0]  lk_q, st_q;
   logic        link_q;
   logic [2:0]  strap_cnt_q;
   mtg_state_t  state_q;
   logic [7:0]  byte_q;
   logic        nib_q, last_q;
   logic [15:0] cnt_q, fc_q;
   logic [31:0] fcs_q;
   logic        ovr_crc_q, ovr_pad_q, ovr_huge_q, ovr_q;
   logic        use_crc, use_pad, use_huge;
   logic [15:0] pad_target;
   logic        byte_done, take_ctrl, load_data, end_frame;
   logic        gap_busy, crc_clear, crc_upd;
   logic [31:0] crc_next;
   logic [7:0]  gap_load;
   logic        tx_act_q;
   logic [15:0] jab_q;
   logic        jab_cut;
   logic        fdx, loop_on;
   logic [31:0] rd_d;

   // Avalon slave: one wait state, write lands on the edge that acks it
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign acc_wr = avs_write & ack_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else if (ce) begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] be);
      wr16 = old;
      if (be[0]) wr16[7:0] = wd[7:0];
      if (be[1]) wr16[15:8] = wd[15:8];
   endfunction

   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mac_control_three_q <= '0;
         back_to_back_gap_q  <= '0;
         phy_control_two_q   <= '0;
         led_control_q       <= LED_RST;
         max_frame_length_q  <= MAX_LEN_RST;
      end else if (ce && acc_wr) begin
         case (avs_address)
            OFF_MAC_CTRL3: if (avs_byteenable[0]) begin
               mac_control_three_q <= avs_writedata[7:0];
            end
            OFF_GAP: if (avs_byteenable[0]) begin
               back_to_back_gap_q <= avs_writedata[7:0] & GAP_MASK;
            end
            OFF_PHY_CTRL2: phy_control_two_q <= wr16(phy_control_two_q,
               avs_writedata, avs_byteenable) & P2_MASK;
            OFF_LED_CTRL: led_control_q <= wr16(led_control_q,
               avs_writedata, avs_byteenable);
            OFF_MAX_LEN: max_frame_length_q <= wr16(max_frame_length_q,
               avs_writedata, avs_byteenable);
            default: ;
         endcase
      end
   end

   // Duplex select: strap caught after release, host may overwrite
   always_ff @(posedge core_clk) begin
      if (reset) begin
         phy_control_one_q <= '0;
         strap_cnt_q       <= '0;
      end else if (ce) begin
         if (strap_cnt_q != 3'h4) begin
            strap_cnt_q <= strap_cnt_q + 3'h1;
            if (strap_cnt_q == 3'h3) begin
               phy_control_one_q[P1_DPX] <= st_q[2];
            end
         end else if (acc_wr && avs_address == OFF_PHY_CTRL1) begin
            phy_control_one_q <= wr16(phy_control_one_q, avs_writedata,
                                      avs_byteenable);
         end
      end
   end

   // Transmit request and sticky status; set wins over clear
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pend_q  <= 1'b0;
         abort_q <= 1'b0;
         under_q <= 1'b0;
         crcb_q  <= 1'b0;
      end else if (ce) begin
         if (acc_wr && avs_address == OFF_TX_CMD && avs_byteenable[0] &&
             avs_writedata[0]) begin
            pend_q <= 1'b1;
         end else if (end_frame) begin
            pend_q <= 1'b0;
         end
         if (acc_wr && avs_address == OFF_STATUS && avs_byteenable[0]) begin
            if (avs_writedata[ST_ABORT]) abort_q <= 1'b0;
            if (avs_writedata[ST_UNDER]) under_q <= 1'b0;
            if (avs_writedata[ST_CRCB])  crcb_q  <= 1'b0;
         end
         if (state_q == MTG_DATA && byte_done && !use_huge &&
             fc_q >= max_frame_length_q) begin
            abort_q <= 1'b1;
         end
         if (load_data && !fr_valid) begin
            under_q <= 1'b1;
         end
         if (state_q == MTG_DATA && byte_done && last_q && !use_crc &&
             !(use_pad && fc_q + 16'd1 < pad_target) &&
             crc_next != CRC_RESIDUE) begin
            crcb_q <= 1'b1;
         end
      end
   end

   // Read mux
   always_comb begin
      rd_d = '0;
      case (avs_address)
         OFF_MAC_CTRL3: rd_d[7:0]  = mac_control_three_q;
         OFF_GAP:       rd_d[7:0]  = back_to_back_gap_q;
         OFF_PHY_CTRL1: rd_d[15:0] = phy_control_one_q;
         OFF_PHY_CTRL2: rd_d[15:0] = phy_control_two_q;
         OFF_LED_CTRL:  rd_d[15:0] = led_control_q;
         OFF_MAX_LEN:   rd_d[15:0] = max_frame_length_q;
         OFF_STATUS: begin
            rd_d[ST_BUSY]  = pend_q;
            rd_d[ST_LINK]  = link_up;
            rd_d[ST_ABORT] = abort_q;
            rd_d[ST_UNDER] = under_q;
            rd_d[ST_CRCB]  = crcb_q;
            rd_d[ST_DMIS]  = fdx ^ phy_control_one_q[P1_DPX];
         end
         default: rd_d = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         avs_readdata <= '0;
      end else if (ce && avs_read && !ack_q) begin
         avs_readdata <= rd_d;
      end
   end

   // Pin synchronisers; link change accepted when stages two and three agree
   always_ff @(posedge core_clk) begin
      if (reset) begin
         lk_q   <= '0;
         st_q   <= '0;
         link_q <= 1'b0;
      end else if (ce) begin
         lk_q <= {lk_q[1:0], link_detect};
         st_q <= {st_q[1:0], duplex_strap};
         if (lk_q[1] == lk_q[2]) begin
            link_q <= lk_q[2];
         end
      end
   end

   assign link_up = link_q | phy_control_two_q[P2_FLINK];
   assign fdx = mac_control_three_q[M3_FDX];

   // Per-frame override selects the frame settings
   assign use_crc  = ovr_q ? ovr_crc_q  : mac_control_three_q[M3_CRC];
   assign use_pad  = ovr_q ? ovr_pad_q  : mac_control_three_q[M3_PAD0];
   assign use_huge = ovr_q ? ovr_huge_q : mac_control_three_q[M3_HUGE];
   assign pad_target = (ovr_q || !mac_control_three_q[M3_PAD1]) ?
                       PAD_SHORT : PAD_LONG;

   assign byte_done = nib_q;
   assign take_ctrl = state_q == MTG_IDLE && pend_q && fr_valid &&
                      !gap_busy;
   assign load_data = byte_done && ((state_q == MTG_PRE && cnt_q == SFD_LAST)
                      || (state_q == MTG_DATA && !last_q &&
                          !(!use_huge && fc_q >= max_frame_length_q)));
   assign fr_ready = ce && (take_ctrl || load_data);
   assign end_frame = ce && state_q != MTG_GAP && state_q != MTG_IDLE &&
                      byte_done && (
      (state_q == MTG_PRE  && cnt_q == SFD_LAST && !fr_valid) ||
      (state_q == MTG_DATA && !use_huge && fc_q >= max_frame_length_q) ||
      (state_q == MTG_DATA && !last_q && !fr_valid) ||
      (state_q == MTG_DATA && last_q && !use_crc &&
       !(use_pad && fc_q + 16'd1 < pad_target)) ||
      (state_q == MTG_PAD && fc_q + 16'd1 >= pad_target && !use_crc) ||
      (state_q == MTG_FCS && cnt_q == FCS_LAST));

   assign crc_clear = take_ctrl;
   assign crc_upd = byte_done && (state_q == MTG_DATA || state_q == MTG_PAD);
   assign gap_load = back_to_back_gap_q +
                     (fdx ? GAP_ADD_FDX : GAP_ADD_HDX);

   mtg_crc32 u_crc (
      .core_clk (core_clk),
      .reset    (reset),
      .ce       (ce),
      .clear    (crc_clear),
      .update   (crc_upd),
      .data     (byte_q),
      .crc_next (crc_next)
   );

   mtg_gap_timer #(.W(8)) u_gap (
      .core_clk (core_clk),
      .reset    (reset),
      .ce       (ce),
      .start    (end_frame),
      .nibbles  (gap_load),
      .busy     (gap_busy)
   );

   // Frame sequencer: preamble, data, pad, FCS, gap
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q    <= MTG_IDLE;
         byte_q     <= '0;
         nib_q      <= 1'b0;
         last_q     <= 1'b0;
         cnt_q      <= '0;
         fc_q       <= '0;
         fcs_q      <= '0;
         ovr_q      <= 1'b0;
         ovr_crc_q  <= 1'b0;
         ovr_pad_q  <= 1'b0;
         ovr_huge_q <= 1'b0;
      end else if (ce) begin
         if (state_q != MTG_IDLE && state_q != MTG_GAP) begin
            nib_q <= ~nib_q;
         end
         if (end_frame) begin
            state_q <= MTG_GAP;
            nib_q   <= 1'b0;
         end else begin
            case (state_q)
               MTG_IDLE: if (take_ctrl) begin
                  ovr_q      <= fr_data[CB_OVR];
                  ovr_crc_q  <= fr_data[CB_CRC];
                  ovr_pad_q  <= fr_data[CB_PAD];
                  ovr_huge_q <= fr_data[CB_HUGE];
                  byte_q     <= PRE_BYTE;
                  cnt_q      <= '0;
                  fc_q       <= '0;
                  nib_q      <= 1'b0;
                  state_q    <= MTG_PRE;
               end
               MTG_PRE: if (byte_done) begin
                  cnt_q  <= cnt_q + 16'd1;
                  byte_q <= (cnt_q == PRE_LAST) ? SFD_BYTE : PRE_BYTE;
                  if (load_data) begin
                     byte_q  <= fr_data;
                     last_q  <= fr_last;
                     state_q <= MTG_DATA;
                  end
               end
               MTG_DATA: if (byte_done) begin
                  fc_q <= fc_q + 16'd1;
                  if (load_data) begin
                     byte_q <= fr_data;
                     last_q <= fr_last;
                  end else if (use_pad && fc_q + 16'd1 < pad_target) begin
                     byte_q  <= '0;
                     state_q <= MTG_PAD;
                  end else begin
                     fcs_q   <= ~crc_next;
                     byte_q  <= ~crc_next[7:0];
                     cnt_q   <= '0;
                     state_q <= MTG_FCS;
                  end
               end
               MTG_PAD: if (byte_done) begin
                  fc_q <= fc_q + 16'd1;
                  if (fc_q + 16'd1 >= pad_target) begin
                     fcs_q   <= ~crc_next;
                     byte_q  <= ~crc_next[7:0];
                     cnt_q   <= '0;
                     state_q <= MTG_FCS;
                  end
               end
               MTG_FCS: if (byte_done) begin
                  cnt_q  <= cnt_q + 16'd1;
                  fcs_q  <= fcs_q >> 8;
                  byte_q <= fcs_q[15:8];
               end
               MTG_GAP: if (!gap_busy) begin
                  state_q <= MTG_IDLE;
               end
               default: state_q <= MTG_IDLE;
            endcase
         end
      end
   end

   // Nibble output, jabber guard, loopback
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tp_tx_data <= '0;
         tx_act_q   <= 1'b0;
         jab_q      <= '0;
      end else if (ce) begin
         tx_act_q   <= state_q != MTG_IDLE && state_q != MTG_GAP;
         tp_tx_data <= nib_q ? byte_q[7:4] : byte_q[3:0];
         if (!tx_act_q) begin
            jab_q <= '0;
         end else if (jab_q != JAB_LIMIT[15:0]) begin
            jab_q <= jab_q + 16'd1;
         end
      end
   end

   assign jab_cut = (jab_q == JAB_LIMIT[15:0]) &&
                    !phy_control_two_q[P2_JAB];
   assign tp_tx_en = tx_act_q && !phy_control_two_q[P2_TXOFF] &&
                     !jab_cut;
   assign loop_on = phy_control_one_q[P1_LOOP] ||
                    (!phy_control_one_q[P1_DPX] &&
                     !phy_control_two_q[P2_HDL]);
   assign loop_valid = tx_act_q && loop_on;
   assign loop_data = tp_tx_data;

   // LED selection
   function automatic logic led_pick(input logic [3:0] sel,
                                     input logic lk, input logic tx,
                                     input logic dp);
      case (sel)
         LED_LINK: led_pick = lk;
         LED_TX:   led_pick = tx;
         LED_DPX:  led_pick = dp;
         LED_ON:   led_pick = 1'b1;
         default:  led_pick = 1'b0;
      endcase
   endfunction

   assign led_out_first = led_pick(led_control_q[LED_OUT_FIRST_LSB+:4], link_up,
      tx_act_q, phy_control_one_q[P1_DPX]);
   assign led_out_second = led_pick(led_control_q[LED_OUT_SECOND_LSB+:4], link_up,
      tx_act_q, phy_control_one_q[P1_DPX]);
endmodule
`default_nettype wire

// [logic/mtg_pkg.sv]
// Shared constants for the transmit gap and PHY control block
package mtg_pkg;
   // Register byte offsets
   localparam logic [4:0] OFF_MAC_CTRL3 = 5'h00;
   localparam logic [4:0] OFF_GAP       = 5'h04;
   localparam logic [4:0] OFF_PHY_CTRL1 = 5'h08;
   localparam logic [4:0] OFF_PHY_CTRL2 = 5'h0C;
   localparam logic [4:0] OFF_LED_CTRL  = 5'h10;
   localparam logic [4:0] OFF_MAX_LEN   = 5'h14;
   localparam logic [4:0] OFF_STATUS    = 5'h18;
   localparam logic [4:0] OFF_TX_CMD    = 5'h1C;
   // mac_control_three fields
   localparam int M3_FDX   = 0;
   localparam int M3_HUGE  = 2;
   localparam int M3_CRC   = 4;
   localparam int M3_PAD0  = 5;
   localparam int M3_PAD1  = 6;
   // phy_control_one fields
   localparam int P1_DPX   = 8;
   localparam int P1_LOOP  = 14;
   // phy_control_two fields
   localparam int P2_HDL   = 8;
   localparam int P2_JAB   = 10;
   localparam int P2_TXOFF = 13;
   localparam int P2_FLINK = 14;
   localparam logic [15:0] P2_MASK  = 16'h7FFF;
   localparam logic [7:0]  GAP_MASK = 8'h7F;
   // Per-frame control byte fields
   localparam int CB_OVR  = 0;
   localparam int CB_CRC  = 1;
   localparam int CB_PAD  = 2;
   localparam int CB_HUGE = 3;
   // Status fields
   localparam int ST_BUSY  = 0;
   localparam int ST_LINK  = 1;
   localparam int ST_ABORT = 2;
   localparam int ST_UNDER = 3;
   localparam int ST_CRCB  = 4;
   localparam int ST_DMIS  = 5;
   // Reset values
   localparam logic [15:0] MAX_LEN_RST = 16'h05EE;
   localparam logic [15:0] LED_RST     = 16'h0120;
   // Gap offsets in nibble times
   localparam logic [7:0] GAP_ADD_FDX = 8'h03;
   localparam logic [7:0] GAP_ADD_HDX = 8'h06;
   // Frame constants
   localparam logic [7:0]  PRE_BYTE  = 8'h55;
   localparam logic [7:0]  SFD_BYTE  = 8'hD5;
   localparam logic [15:0] PRE_LAST  = 16'h0006;
   localparam logic [15:0] SFD_LAST  = 16'h0007;
   localparam logic [15:0] PAD_SHORT = 16'h003C;
   localparam logic [15:0] PAD_LONG  = 16'h0040;
   localparam logic [15:0] FCS_LAST  = 16'h0003;
   localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
   localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
   // LED selector codes
   localparam logic [3:0] LED_LINK = 4'h0;
   localparam logic [3:0] LED_TX   = 4'h1;
   localparam logic [3:0] LED_DPX  = 4'h2;
   localparam logic [3:0] LED_ON   = 4'h3;
   localparam int LED_OUT_FIRST_LSB = 8;
   localparam int LED_OUT_SECOND_LSB = 4;
   typedef enum logic [2:0] {
      MTG_IDLE = 3'b000,
      MTG_PRE  = 3'b001,
      MTG_DATA = 3'b011,
      MTG_PAD  = 3'b010,
      MTG_FCS  = 3'b110,
      MTG_GAP  = 3'b111
   } mtg_state_t;
endpackage

// [logic/mtg_crc32.sv]
// Byte-wide CRC-32 accumulator for the transmit path
`timescale 1ns/1ps
`default_nettype none
module mtg_crc32 (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   // Control and data
   input  wire logic        clear,
   input  wire logic        update,
   input  wire logic [7:0]  data,
   output logic      [31:0] crc_next
);
   import mtg_pkg::*;
   logic [31:0] crc_q;

   // Combinational next value over one byte, LSB first
   always_comb begin
      crc_next = crc_q;
      for (int i = 0; i < 8; i++) begin
         if (crc_next[0] ^ data[i]) begin
            crc_next = (crc_next >> 1) ^ CRC_POLY;
         end else begin
            crc_next = crc_next >> 1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         crc_q <= CRC_INIT;
      end else if (ce) begin
         if (clear) begin
            crc_q <= CRC_INIT;
         end else if (update) begin
            crc_q <= crc_next;
         end
      end
   end
endmodule
`default_nettype wire

// [logic/mtg_gap_timer.sv]
// Nibble-time countdown for the back-to-back gap
`timescale 1ns/1ps
`default_nettype none
module mtg_gap_timer #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         reset,
   input  wire logic         ce,
   // Control
   input  wire logic         start,
   input  wire logic [W-1:0] nibbles,
   output logic              busy
);
   logic [W-1:0] cnt_q;

   assign busy = (cnt_q != '0);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (ce) begin
         if (start) begin
            cnt_q <= nibbles;
         end else if (busy) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/mtg_tx_top_checker.sv]
// Port-level assertions for the transmit gap block
`timescale 1ns/1ps
`default_nettype none
module mtg_tx_top_checker
   import mtg_pkg::*;
(
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // Register bus
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Pins
   input wire logic        link_detect,
   input wire logic [3:0]  tp_tx_data,
   input wire logic        tp_tx_en,
   input wire logic        link_up
);
   logic [7:0] gap_q;
   logic [7:0] idle_q;
   logic       fdx_q;
   logic [1:0] p2_q;
   wire        wr_ok = avs_write & ~avs_waitrequest;
   wire        rd_ok = avs_read & ~avs_waitrequest;
   // Shadow of the register bits the checks need
   always_ff @(posedge core_clk) begin
      if (reset) begin
         gap_q <= 8'h00;
         fdx_q <= 1'h0;
         p2_q  <= 2'h0;
      end else if (wr_ok) begin
         if (avs_address == OFF_GAP) gap_q <= {1'h0, avs_writedata[6:0]};
         if (avs_address == OFF_MAC_CTRL3) fdx_q <= avs_writedata[M3_FDX];
         if (avs_address == OFF_PHY_CTRL2) p2_q <= avs_writedata[14:13];
      end
   end
   // Idle cycles since the transmitter last ran
   always_ff @(posedge core_clk) begin
      if (reset) idle_q <= 8'hFF;
      else if (tp_tx_en) idle_q <= 8'h00;
      else if (idle_q != 8'hFF) idle_q <= idle_q + 8'h01;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus wait too long");
   gap_len_a: assert property ($rose(tp_tx_en) |->
      idle_q >= gap_q + (fdx_q ? GAP_ADD_FDX : GAP_ADD_HDX))
      else $error("gap too short");
   preamble_a: assert property ($rose(tp_tx_en) |->
      (tp_tx_data == 4'h5) [*8] ##1 (tp_tx_data == 4'h5) [*7]
      ##1 tp_tx_data == 4'hD) else $error("bad preamble");
   tx_off_a: assert property (p2_q[0] |-> !tp_tx_en)
      else $error("transmitter not off");
   force_link_a: assert property (p2_q[1] |-> link_up)
      else $error("link not forced");
   link_seen_a: assert property (link_detect [*6] |-> link_up)
      else $error("link not seen");
   gap_top_a: assert property (rd_ok && avs_address == OFF_GAP
      |-> !avs_readdata[7]) else $error("gap top bit set");
   phy_top_a: assert property (rd_ok && avs_address == OFF_PHY_CTRL2
      |-> !avs_readdata[15]) else $error("phy top bit set");
   c_frame: cover property ($rose(tp_tx_en));
   c_read: cover property (rd_ok);
   c_force: cover property (p2_q[1] && !link_detect);
endmodule
bind mtg_tx_top mtg_tx_top_checker u_chk (.core_clk, .reset, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
   .link_detect, .tp_tx_data, .tp_tx_en, .link_up);
`default_nettype wire

// [testbench/mtg_frame_src.sv]
// Buffer memory stand-in: control byte, then frame bytes
`timescale 1ns/1ps
`default_nettype none
module mtg_frame_src (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Frame set-up
   input  wire logic       go,
   input  wire logic [7:0] ctl,
   input  wire logic [7:0] len,
   // Byte stream
   input  wire logic       fr_ready,
   output logic      [7:0] fr_data,
   output logic            fr_valid,
   output logic            fr_last
);
   logic [7:0] idx_q;
   logic       act_q;
   logic [7:0] byte_w;
   assign byte_w   = idx_q == 8'h00 ? ctl : idx_q + 8'h10;
   assign fr_valid = act_q;
   // Idle bus shows the inverse so no stale byte passes
   assign fr_data  = act_q ? byte_w : ~byte_w;
   assign fr_last  = act_q && idx_q == len;
   always_ff @(posedge core_clk) begin
      if (reset || go) begin
         idx_q <= 8'h00;
         act_q <= go;
      end else if (fr_ready && act_q) begin
         idx_q <= idx_q + 8'h01;
         act_q <= !fr_last;
      end
   end
endmodule
`default_nettype wire

// [testbench/test_mac_tx_gap_phy_ctrl.sv]
// Bench for the transmit gap and PHY control block
`timescale 1ns/1ps
`default_nettype none
module test_mac_tx_gap_phy_ctrl;
   import mtg_pkg::*;
   typedef struct packed {
      logic [7:0]  m3;
      logic [15:0] p1;
      logic [15:0] p2;
      logic [7:0]  ctl;
      logic [7:0]  nb;
      logic [1:0]  fl;
   } mtg_row_t;
   // Config, control byte, bytes after delimiter, FCS and loop flags
   mtg_row_t    rows [7] = '{
      '{8'h00, 16'h0000, 16'h0000, 8'h01, 8'h0A, 2'h1},
      '{8'h00, 16'h0000, 16'h0500, 8'h07, 8'h40, 2'h2},
      '{8'h00, 16'h4000, 16'h0100, 8'h03, 8'h0E, 2'h3},
      '{8'h31, 16'h0100, 16'h0500, 8'hF0, 8'h40, 2'h2},
      '{8'h71, 16'h0100, 16'h0400, 8'h00, 8'h44, 2'h2},
      '{8'h31, 16'h0100, 16'h2000, 8'h00, 8'h00, 2'h0},
      '{8'h31, 16'h0100, 16'h0100, 8'h00, 8'h2A, 2'h0}};
   logic        core_clk = 1'h0;
   logic        reset = 1'h1;
   logic        avs_read = 1'h0;
   logic        avs_write = 1'h0;
   logic        go = 1'h0;
   logic        link_detect = 1'h0;
   logic [4:0]  avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [7:0]  ctl = 8'h00;
   logic [31:0] avs_readdata, rd;
   logic [7:0]  fr_data;
   logic [3:0]  tp_tx_data, loop_data;
   logic        avs_waitrequest, fr_valid, fr_last, fr_ready, tp_tx_en;
   logic        loop_valid, link_up, led_out_first, led_out_second;
   logic [3:0]  nib [$];
   int          n_mismatch = 0, total_checks = 0, loop_cnt, idle, last_idle;
   mtg_tx_top #(.JAB_LIMIT(100)) dut (.core_clk, .reset, .ce(1'h1),
      .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .fr_data,
      .fr_valid, .fr_last, .fr_ready, .link_detect, .duplex_strap(1'h1),
      .tp_tx_data, .tp_tx_en, .loop_data, .loop_valid, .link_up,
      .led_out_first, .led_out_second);
   mtg_frame_src src (.core_clk, .reset, .go, .ctl, .len(8'h0A), .fr_ready,
      .fr_data, .fr_valid, .fr_last);
   initial forever #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (tp_tx_en === 1'h1) nib.push_back(tp_tx_data);
      if (loop_valid === 1'h1) loop_cnt++;
      if (tp_tx_en === 1'h1 && idle > 0) last_idle = idle;
      idle = tp_tx_en === 1'h1 ? 0 : idle + 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic we, input logic [4:0] a,
                      input logic [31:0] d);
      avs_write <= we;
      avs_read <= !we;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic send(input logic [7:0] c);
      ctl <= c;
      go <= 1'h1;
      @(posedge core_clk);
      go <= 1'h0;
      bus(1'h1, OFF_TX_CMD, 32'h1);
   endtask
   task automatic wait_idle;
      do bus(1'h0, OFF_STATUS, 32'h0); while (rd[ST_BUSY] !== 1'h0);
   endtask
   function automatic logic [31:0] crc_upd(logic [31:0] c, logic [7:0] b);
      c = c ^ {24'h0, b};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      return c;
   endfunction
   task automatic give_verdict;
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #1000000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      logic [7:0]  b;
      logic [31:0] c;
      repeat (20) @(posedge core_clk);
      reset <= 1'h0;
      repeat (4) @(posedge core_clk);
      bus(1'h0, OFF_PHY_CTRL1, 32'h0);
      chk(rd[P1_DPX], 1'h1);
      bus(1'h0, OFF_LED_CTRL, 32'h0);
      chk(rd, {16'h0, LED_RST});
      bus(1'h1, OFF_GAP, 32'hFF);
      bus(1'h0, OFF_GAP, 32'h0);
      chk(rd, 32'h7F);
      bus(1'h1, OFF_PHY_CTRL2, 32'hFFFF);
      bus(1'h0, OFF_PHY_CTRL2, 32'h0);
      chk(rd, 32'h7FFF);
      chk(link_up, 1'h1);
      bus(1'h1, OFF_PHY_CTRL2, 32'h400);
      chk(link_up, 1'h0);
      bus(1'h1, OFF_LED_CTRL, 32'h0300);
      chk(led_out_first, 1'h1);
      link_detect <= 1'h1;
      repeat (8) @(posedge core_clk);
      chk(link_up, 1'h1);
      for (int f = 1; f >= 0; f--) begin
         bus(1'h1, OFF_MAC_CTRL3, f ? 32'h31 : 32'h30);
         bus(1'h1, OFF_PHY_CTRL1, f ? 32'h100 : 32'h0);
         bus(1'h1, OFF_GAP, f ? 32'h15 : 32'h12);
         send(8'h00);
         @(negedge tp_tx_en);
         @(posedge core_clk);
         send(8'h00);
         wait_idle();
         chk(last_idle >= 24 && last_idle <= 26, 1'h1);
      end
      foreach (rows[i]) begin
         bus(1'h1, OFF_MAC_CTRL3, {24'h0, rows[i].m3});
         bus(1'h1, OFF_PHY_CTRL1, {16'h0, rows[i].p1});
         bus(1'h1, OFF_PHY_CTRL2, {16'h0, rows[i].p2});
         nib.delete();
         loop_cnt = 0;
         send(rows[i].ctl);
         wait_idle();
         chk(nib.size(), rows[i].nb ? 2 * (rows[i].nb + 8) : 0);
         chk(loop_cnt != 0, rows[i].fl[0]);
         c = CRC_INIT;
         for (int k = 0; 2 * k + 1 < nib.size(); k++) begin
            b = {nib[2 * k + 1], nib[2 * k]};
            if (k >= 8) c = crc_upd(c, b);
            if (k < 8) chk(b, k < 7 ? PRE_BYTE : SFD_BYTE);
            else if (k < rows[i].nb + 8 - 4 * rows[i].fl[1])
               chk(b, k < 18 ? k + 9 : 0);
         end
         if (rows[i].fl[1]) chk(c, CRC_RESIDUE);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
